/* logic/mpm_ctrl.sv */
// Controller-side sequencer for power states, calibration and refresh timing
// How it works
// - On light-sleep or power-down entry the row and column bits stay quiet at least four cycles.
// - The row and column quiet bits rise with the entry packet and are held together for five cycles.
// - A current-calibration packet waits twelve cycles after read data from the device.
// - Read data is not scheduled until eight cycles after a current-calibration packet.
// - Both link clocks run stably for two cycles before a low-power exit starts.
// - Both link clocks stay stable for a hundred cycles after low-power entry.
// - A column packet follows a waking row packet by at least seven cycles.
// - Light sleep is left before ten microseconds have passed.
// - After deep power-down or self-refresh sleep exit every bank is refreshed within 200 us.
// - The temperature-calibrate command comes at least 150 cycles after its enable command.
// - The temperature quiet window starts exactly two cycles after the calibrate command.
// - No read data is scheduled during the 140-cycle temperature quiet window.
// - Nothing is driven on the fast buses during the initial pause after reset.
`timescale 1ns/10ps
module mpm_ctrl #(
  parameter int unsigned BANKS      = 32,
  parameter int unsigned PAUSE_CYC  = mpm_pkg::T_PAUSE_CYC,
  parameter int unsigned BURST_CYC  = mpm_pkg::T_BURST_CYC,
  parameter int unsigned NLIMIT_LC  = mpm_pkg::T_NLIMIT_LCYC
) (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       link_clock,
  input  wire logic       req_valid,
  input  wire logic [3:0] req_cmd,
  input  wire logic       req_self_refresh,
  output logic            req_ready,
  output logic            bus_valid,
  output logic [3:0]      bus_cmd,
  output logic            row_quiet_bit,
  output logic            column_quiet_bit,
  output logic            clk_stop_ok,
  output logic            nap_expired,
  output logic            refresh_due,
  output logic            pause_done,
  output logic            temp_calibrate_command_quiet
);
  typedef enum logic [2:0] {
    MPM_S_PAUSE = 3'b000,
    MPM_S_RUN   = 3'b001,
    MPM_S_ENTER = 3'b010,
    MPM_S_LOW   = 3'b011,
    MPM_S_EXIT  = 3'b100
  } mpm_state_e;

  typedef struct packed {
    mpm_state_e                  st;
    logic [31:0]                 pause_cnt;
    logic [31:0]                 burst_cnt;
    logic [7:0]                  step_cnt;
    logic [7:0]                  tce_cnt;
    logic                        tce_seen;
    logic [7:0]                  tq_cnt;
    logic [1:0]                  tq_lead;
    logic [BANKS-1:0]            refd;
    logic                        burst_on;
    logic                        is_nap;
    logic                        ready;
    logic                        bvalid;
    logic [3:0]                  bcmd;
    logic                        quiet;
    logic                        stop_ok;
    logic                        due;
    logic                        pdone;
    logic                        tquiet;
  } mpm_ctrl_s;

  mpm_ctrl_s s_q;
  mpm_ctrl_s s_d;

  // Light-sleep residency counted on the link clock; crosses back as a level
  logic [15:0] nap_lcnt_q;
  logic        nap_on_sync;
  logic        nap_over_q;
  logic        nap_over_sync;

  mpm_sync u_nap_to_link (
    .clock (link_clock),
    .rst   (rst),
    .d     (s_q.is_nap),
    .q     (nap_on_sync)
  );

  always_ff @(posedge link_clock)
  begin
    if (rst)
    begin
      nap_lcnt_q <= 16'h0000;
      nap_over_q <= 1'b0;
    end
    else if (!nap_on_sync)
    begin
      nap_lcnt_q <= 16'h0000;
      nap_over_q <= 1'b0;
    end
    else
    begin
      // Margin for the crossing in and the crossing back
      if (nap_lcnt_q + 16'h0004 >= NLIMIT_LC[15:0])
        nap_over_q <= 1'b1;
      else
        nap_lcnt_q <= nap_lcnt_q + 16'h0001;
    end
  end

  mpm_sync u_nap_to_sys (
    .clock (clock),
    .rst   (rst),
    .d     (nap_over_q),
    .q     (nap_over_sync)
  );

  // Gap timers for the read/calibration spacing and the row-to-column framing delay
  logic cc_block;
  logic rd_block;
  logic col_block;
  logic issue;
  logic is_rd;
  logic is_cc;
  logic is_row;

  mpm_gap #(.W(8)) u_rd_to_cc (
    .clock (clock),
    .rst   (rst),
    .load  (issue && is_rd),
    .val   (8'(mpm_pkg::T_READTOCC_CYC)),
    .busy  (cc_block)
  );
  mpm_gap #(.W(8)) u_cc_to_rd (
    .clock (clock),
    .rst   (rst),
    .load  (issue && is_cc),
    .val   (8'(mpm_pkg::T_CCTOREAD_CYC)),
    .busy  (rd_block)
  );
  mpm_gap #(.W(8)) u_row_to_col (
    .clock (clock),
    .rst   (rst),
    .load  (issue && is_row),
    .val   (8'(mpm_pkg::T_FRM_CYC)),
    .busy  (col_block)
  );

  assign is_rd  = (req_cmd == mpm_pkg::MPM_CMD_READ);
  assign is_cc  = (req_cmd == mpm_pkg::MPM_CMD_CC);
  assign is_row = (req_cmd == mpm_pkg::MPM_CMD_ROWACT);

  function automatic logic allowed(input mpm_ctrl_s s, input logic [3:0] c,
                                   input logic ccb, input logic rdb, input logic colb);
    logic ok;
    ok = 1'b1;
    case (c)
      mpm_pkg::MPM_CMD_CC:   ok = !ccb;
      mpm_pkg::MPM_CMD_READ: ok = !rdb && !s.tquiet && (s.tq_lead == 2'b00);
      mpm_pkg::MPM_CMD_COL:  ok = !colb;
      mpm_pkg::MPM_CMD_TEMP_CALIBRATE_COMMAND: ok = s.tce_seen && (s.tce_cnt >= 8'(mpm_pkg::T_TCEN_CYC));
      default:               ok = 1'b1;
    endcase
    return ok;
  endfunction : allowed

  assign issue = (s_q.st == MPM_S_RUN) && req_valid && s_q.ready
                 && allowed(s_q, req_cmd, cc_block, rd_block, col_block);

  always_comb
  begin
    s_d        = s_q;
    s_d.bvalid = 1'b0;
    s_d.bcmd   = mpm_pkg::MPM_CMD_NONE;
    if (s_q.tce_seen && s_q.tce_cnt != 8'hFF)
      s_d.tce_cnt = s_q.tce_cnt + 8'h01;
    // quiet window two cycles after calibrate
    if (s_q.tq_lead != 2'b00)
    begin
      s_d.tq_lead = s_q.tq_lead - 2'b01;
      if (s_q.tq_lead == 2'b01)
      begin
        s_d.tquiet = 1'b1;
        s_d.tq_cnt = 8'(mpm_pkg::T_TCQUIET_CYC);
      end
    end
    else if (s_q.tq_cnt != 8'h00)
    begin
      s_d.tq_cnt = s_q.tq_cnt - 8'h01;
      s_d.tquiet = (s_q.tq_cnt != 8'h01);
    end
    if (s_q.burst_on)
    begin
      if (s_q.burst_cnt != 32'h0)
        s_d.burst_cnt = s_q.burst_cnt - 32'h1;
      s_d.due = 1'b1;
      if (&s_q.refd)
      begin
        s_d.burst_on = 1'b0;
        s_d.due      = 1'b0;
      end
    end
    case (s_q.st)
      MPM_S_PAUSE:
      begin
        s_d.ready = 1'b0;
        if (s_q.pause_cnt == 32'h0)
        begin
          s_d.st    = MPM_S_RUN;
          s_d.pdone = 1'b1;
          s_d.ready = 1'b1;
        end
        else
          s_d.pause_cnt = s_q.pause_cnt - 32'h1;
      end
      MPM_S_RUN:
      begin
        if (issue)
        begin
          s_d.bvalid = 1'b1;
          s_d.bcmd   = req_cmd;
          if (req_cmd == mpm_pkg::MPM_CMD_TCE)
          begin
            s_d.tce_seen = 1'b1;
            s_d.tce_cnt  = 8'h01;
          end
          if (req_cmd == mpm_pkg::MPM_CMD_TEMP_CALIBRATE_COMMAND)
          begin
            s_d.tce_seen = 1'b0;
            s_d.tq_lead  = 2'(mpm_pkg::T_TEMP_CALIBRATE_COMMAND_CYC);
          end
          if (req_cmd == mpm_pkg::MPM_CMD_NAP || req_cmd == mpm_pkg::MPM_CMD_PDN)
          begin
            s_d.st       = MPM_S_ENTER;
            s_d.ready    = 1'b0;
            s_d.quiet    = 1'b1;
            s_d.is_nap   = (req_cmd == mpm_pkg::MPM_CMD_NAP);
            s_d.stop_ok  = 1'b0;
            s_d.step_cnt = 8'(mpm_pkg::T_H4_CYC);
          end
        end
      end
      MPM_S_ENTER:
      begin
        if (s_q.step_cnt <= 8'h01)
        begin
          s_d.quiet    = 1'b0;
          s_d.st       = MPM_S_LOW;
          s_d.step_cnt = 8'(mpm_pkg::T_CD_CYC - mpm_pkg::T_H4_CYC);
        end
        else
          s_d.step_cnt = s_q.step_cnt - 8'h01;
      end
      MPM_S_LOW:
      begin
        if (s_q.step_cnt != 8'h00)
          s_d.step_cnt = s_q.step_cnt - 8'h01;
        else
          s_d.stop_ok = 1'b1;
        // exit once clocks settle, on an exit request or at residency limit
        if (s_q.step_cnt == 8'h00 &&
            (nap_over_sync || (req_valid && req_cmd == mpm_pkg::MPM_CMD_EXIT)))
        begin
          s_d.stop_ok  = 1'b0;
          s_d.st       = MPM_S_EXIT;
          s_d.step_cnt = 8'(mpm_pkg::T_CE_CYC);
        end
      end
      MPM_S_EXIT:
      begin
        if (s_q.step_cnt != 8'h00)
          s_d.step_cnt = s_q.step_cnt - 8'h01;
        else
        begin
          s_d.st     = MPM_S_RUN;
          s_d.ready  = 1'b1;
          s_d.bvalid = 1'b1;
          s_d.bcmd   = mpm_pkg::MPM_CMD_EXIT;
          if (!s_q.is_nap || req_self_refresh)
          begin
            s_d.burst_on  = 1'b1;
            s_d.burst_cnt = BURST_CYC;
            s_d.refd      = '0;
          end
          s_d.is_nap = 1'b0;
        end
      end
      default:
        s_d.st = MPM_S_PAUSE;
    endcase
    // Shift one bank per refresh so all banks are covered
    if (issue && req_cmd == mpm_pkg::MPM_CMD_REFR)
      s_d.refd = {s_q.refd[BANKS-2:0], 1'b1};
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      s_q           <= '0;
      s_q.st        <= MPM_S_PAUSE;
      s_q.pause_cnt <= PAUSE_CYC;
      s_q.refd      <= '1;
    end
    else
      s_q <= s_d;
  end

  assign req_ready        = s_q.ready;
  assign bus_valid        = s_q.bvalid;
  assign bus_cmd          = s_q.bcmd;
  assign row_quiet_bit    = s_q.quiet;
  assign column_quiet_bit = s_q.quiet;
  assign clk_stop_ok      = s_q.stop_ok;
  assign nap_expired      = nap_over_sync;
  assign refresh_due      = s_q.due;
  assign pause_done       = s_q.pdone;
  assign temp_calibrate_command_quiet       = s_q.tquiet;

  quiet_hold_a: assert property (@(posedge clock) disable iff (rst)
    $rose(row_quiet_bit) |-> row_quiet_bit[*4])
    else $error("quiet window shorter than four cycles");
  // both quiet bits together, five cycles
  quiet_pair_a: assert property (@(posedge clock) disable iff (rst)
    $rose(row_quiet_bit) |-> (row_quiet_bit && column_quiet_bit)[*5])
    else $error("quiet bits not held five cycles");
  sequence rd_seq;
    bus_valid && bus_cmd == mpm_pkg::MPM_CMD_READ;
  endsequence
  read_cc_gap_a: assert property (@(posedge clock) disable iff (rst)
    rd_seq |-> ##1 !(bus_valid && bus_cmd == mpm_pkg::MPM_CMD_CC)[*8]
      ##1 !(bus_valid && bus_cmd == mpm_pkg::MPM_CMD_CC)[*3])
    else $error("calibration packet too soon after read");
  cc_read_gap_a: assert property (@(posedge clock) disable iff (rst)
    (bus_valid && bus_cmd == mpm_pkg::MPM_CMD_CC) |->
      ##1 !(bus_valid && bus_cmd == mpm_pkg::MPM_CMD_READ)[*7])
    else $error("read too soon after calibration packet");
  frame_gap_a: assert property (@(posedge clock) disable iff (rst)
    (bus_valid && bus_cmd == mpm_pkg::MPM_CMD_ROWACT) |->
      ##1 !(bus_valid && bus_cmd == mpm_pkg::MPM_CMD_COL)[*6])
    else $error("column packet inside framing delay");
  temp_calibrate_command_offset_a: assert property (@(posedge clock) disable iff (rst)
    (bus_valid && bus_cmd == mpm_pkg::MPM_CMD_TEMP_CALIBRATE_COMMAND) |-> ##2 temp_calibrate_command_quiet)
    else $error("quiet window not two cycles after calibrate");
  temp_calibrate_command_noread_a: assert property (@(posedge clock) disable iff (rst)
    temp_calibrate_command_quiet |-> !(bus_valid && bus_cmd == mpm_pkg::MPM_CMD_READ))
    else $error("read during temperature quiet window");
  pause_idle_a: assert property (@(posedge clock) disable iff (rst)
    !pause_done |-> !bus_valid && !req_ready)
    else $error("bus active during initial pause");
  clk_hold_a: assert property (@(posedge clock) disable iff (rst)
    (bus_valid && (bus_cmd == mpm_pkg::MPM_CMD_NAP || bus_cmd == mpm_pkg::MPM_CMD_PDN))
      |-> !clk_stop_ok throughout (##99 1'b1))
    else $error("clock stop allowed too early");
  burst_time_a: assert property (@(posedge clock) disable iff (rst)
    refresh_due |-> s_q.burst_cnt != 32'h0)
    else $error("refresh burst not finished in time");
endmodule : mpm_ctrl

/* logic/mpm_pkg.sv */
// Package: timing constants and commands for the memory power/maintenance sequencer
package mpm_pkg;
  localparam int unsigned CLK_MHZ          = 50;
  localparam int unsigned LINK_NS          = 125;
  localparam int unsigned T_NPQ_CYC        = 4;
  localparam int unsigned T_H4_CYC         = 5;
  localparam int signed   T_S4_CYC         = -1;
  localparam int unsigned T_READTOCC_CYC   = 12;
  localparam int unsigned T_CCTOREAD_CYC   = 8;
  localparam int unsigned T_CE_CYC         = 2;
  localparam int unsigned T_CD_CYC         = 100;
  localparam int unsigned T_FRM_CYC        = 7;
  localparam int unsigned T_NLIMIT_NS      = 10000;
  localparam int unsigned T_BURST_NS       = 200000;
  localparam int unsigned T_TCEN_CYC       = 150;
  localparam int unsigned T_TEMP_CALIBRATE_COMMAND_CYC       = 2;
  localparam int unsigned T_TCQUIET_CYC    = 140;
  localparam int unsigned T_PAUSE_NS       = 200000;
  // Longest times round down, in link cycles
  localparam int unsigned T_NLIMIT_LCYC    = T_NLIMIT_NS / LINK_NS;
  // Local clock cycles for long waits
  localparam int unsigned T_BURST_CYC      = T_BURST_NS * CLK_MHZ / 1000;
  localparam int unsigned T_PAUSE_CYC      = T_PAUSE_NS * CLK_MHZ / 1000;
  localparam int unsigned CNT_W            = 16;
  typedef enum logic [3:0] {
    MPM_CMD_NONE   = 4'h0,
    MPM_CMD_ROWACT = 4'h1,
    MPM_CMD_COL    = 4'h2,
    MPM_CMD_CC     = 4'h3,
    MPM_CMD_TCE    = 4'h4,
    MPM_CMD_TEMP_CALIBRATE_COMMAND   = 4'h5,
    MPM_CMD_NAP    = 4'h6,
    MPM_CMD_PDN    = 4'h7,
    MPM_CMD_EXIT   = 4'h8,
    MPM_CMD_REFR   = 4'h9,
    MPM_CMD_READ   = 4'hA
  } mpm_cmd_e;
endpackage : mpm_pkg

/* logic/mpm_sync.sv */
// Two-flop synchroniser for single-bit levels
`timescale 1ns/10ps
module mpm_sync (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic d,
  output logic      q
);
  logic meta_q;
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      meta_q <= 1'b0;
      q      <= 1'b0;
    end
    else
    begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : mpm_sync

/* logic/mpm_gap.sv */
// Countdown timer: busy until the loaded gap expires
`timescale 1ns/10ps
module mpm_gap #(
  parameter int unsigned W = 16
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         load,
  input  wire logic [W-1:0] val,
  output logic              busy
);
  logic [W-1:0] cnt_q;
  always_ff @(posedge clock)
  begin
    if (rst)
      cnt_q <= '0;
    else if (load)
      cnt_q <= val;
    else if (cnt_q != '0)
      cnt_q <= cnt_q - 1'b1;
  end
  assign busy = (cnt_q != '0);
endmodule : mpm_gap

/* verif/mpm_dev_model.sv */
// Device-side model that watches commands and quiet bits for spacing faults
`timescale 1ns/10ps
module mpm_dev_model #(
  parameter int PAUSE_CYC = 20,
  parameter int NAP_MAX   = 140
) (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       bus_valid,
  input  wire logic [3:0] bus_cmd,
  input  wire logic       row_quiet_bit,
  input  wire logic       column_quiet_bit,
  output int              errs
);
  int   cyc;
  int   n_q;
  int   t_low;
  int   t [16];
  logic in_nap;
  logic q;
  // Outputs seen one edge late, so spacing stays exact
  always @(posedge clock)
  begin
    q = row_quiet_bit && column_quiet_bit;
    if (rst)
    begin
      cyc = 0;
      errs = 0;
      n_q = 0;
      t_low = -999;
      in_nap = 1'b0;
      foreach (t[i]) t[i] = -999;
    end
    else
    begin
      cyc++;
      if (n_q > 0 && n_q < 5 && !q)
        errs++;
      n_q = q ? n_q + 1 : 0;
      if (bus_valid)
      begin
        if (cyc <= PAUSE_CYC)
          errs++;
        if (bus_cmd == mpm_pkg::MPM_CMD_CC && cyc - t[mpm_pkg::MPM_CMD_READ] < 12)
          errs++;
        if (bus_cmd == mpm_pkg::MPM_CMD_READ && cyc - t[mpm_pkg::MPM_CMD_CC] < 8)
          errs++;
        if (bus_cmd == mpm_pkg::MPM_CMD_READ && cyc - t[mpm_pkg::MPM_CMD_TEMP_CALIBRATE_COMMAND] < 142)
          errs++;
        if (bus_cmd == mpm_pkg::MPM_CMD_COL && cyc - t[mpm_pkg::MPM_CMD_ROWACT] < 7)
          errs++;
        if (bus_cmd == mpm_pkg::MPM_CMD_TEMP_CALIBRATE_COMMAND && cyc - t[mpm_pkg::MPM_CMD_TCE] < 150)
          errs++;
        if (bus_cmd == mpm_pkg::MPM_CMD_EXIT && cyc - t_low < 100)
          errs++;
        if (bus_cmd == mpm_pkg::MPM_CMD_EXIT && in_nap && cyc - t_low > NAP_MAX)
          errs++;
        if (bus_cmd == mpm_pkg::MPM_CMD_NAP || bus_cmd == mpm_pkg::MPM_CMD_PDN)
        begin
          t_low = cyc;
          in_nap = bus_cmd == mpm_pkg::MPM_CMD_NAP;
          if (n_q == 0)
            errs++;
        end
        t[bus_cmd] = cyc;
      end
    end
  end
endmodule : mpm_dev_model

/* verif/memory_power_and_maintenance_timing_bench.sv */
// Self-checking bench for the power and maintenance sequencer
`timescale 1ns/10ps
module memory_power_and_maintenance_timing_bench;
  localparam int PAUSE = 20;
  localparam int BANKS = 4;
  localparam int LIMIT = 6000;
  logic       clock = 1'b0;
  logic       link_clock = 1'b0;
  logic       rst = 1'b1;
  logic       req_valid = 1'b0;
  logic [3:0] req_cmd = 4'h0;
  logic       req_self_refresh = 1'b0;
  logic       req_ready, bus_valid, row_quiet_bit, column_quiet_bit, clk_stop_ok;
  logic       nap_expired, refresh_due, pause_done, temp_calibrate_command_quiet;
  logic [3:0] bus_cmd;
  logic [3:0] pick [5] = '{4'hA, 4'h3, 4'h1, 4'h2, 4'h9};
  int         cyc = 0, mismatches = 0, n_compared = 0, t_go = 0, n, dev_errs;
  int         t [16];

  mpm_ctrl #(.BANKS(BANKS), .PAUSE_CYC(PAUSE), .BURST_CYC(50), .NLIMIT_LC(20)) uut (
    .clock(clock), .rst(rst), .link_clock(link_clock), .req_valid(req_valid),
    .req_cmd(req_cmd), .req_self_refresh(req_self_refresh), .req_ready(req_ready),
    .bus_valid(bus_valid), .bus_cmd(bus_cmd), .row_quiet_bit(row_quiet_bit),
    .column_quiet_bit(column_quiet_bit), .clk_stop_ok(clk_stop_ok),
    .nap_expired(nap_expired), .refresh_due(refresh_due), .pause_done(pause_done),
    .temp_calibrate_command_quiet(temp_calibrate_command_quiet));

  mpm_dev_model #(.PAUSE_CYC(PAUSE), .NAP_MAX(140)) dev (
    .clock(clock), .rst(rst), .bus_valid(bus_valid), .bus_cmd(bus_cmd),
    .row_quiet_bit(row_quiet_bit), .column_quiet_bit(column_quiet_bit), .errs(dev_errs));

  initial forever #10 clock = ~clock;
  // Odd offset keeps the link clock unrelated in phase
  initial
  begin
    #7;
    forever #62.5 link_clock = ~link_clock;
  end

  task finish_test;
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test

  always @(posedge clock)
  begin
    cyc++;
    if (cyc >= LIMIT)
    begin
      mismatches++;
      finish_test();
    end
  end

  task automatic check(input bit ok, input string msg);
    n_compared++;
    if (!ok)
    begin
      mismatches++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : check

  function automatic int imax(input int a, input int b);
    return a > b ? a : b;
  endfunction : imax

  // Earliest edge on which a command may reach the bus
  function automatic int earliest(input logic [3:0] c);
    int e;
    e = imax(cyc + 1, t_go);
    if (c == mpm_pkg::MPM_CMD_READ)
      e = imax(e, imax(t[mpm_pkg::MPM_CMD_CC] + 8, t[mpm_pkg::MPM_CMD_TEMP_CALIBRATE_COMMAND] + 142));
    if (c == mpm_pkg::MPM_CMD_CC)
      e = imax(e, t[mpm_pkg::MPM_CMD_READ] + 12);
    if (c == mpm_pkg::MPM_CMD_COL)
      e = imax(e, t[mpm_pkg::MPM_CMD_ROWACT] + 7);
    if (c == mpm_pkg::MPM_CMD_TEMP_CALIBRATE_COMMAND)
      e = imax(e, t[mpm_pkg::MPM_CMD_TCE] + 150);
    if (c == mpm_pkg::MPM_CMD_EXIT)
      // Hold, then the accept edge, the settle wait and the pulse
      e = imax(e + 1 + mpm_pkg::T_CE_CYC, imax(t[mpm_pkg::MPM_CMD_NAP], t[mpm_pkg::MPM_CMD_PDN])
               + mpm_pkg::T_CD_CYC + mpm_pkg::T_CE_CYC + 2);
    return e;
  endfunction : earliest

  // Called at a falling edge; request held until the pulse shows
  task automatic send(input logic [3:0] c, input int slack);
    int e;
    int k;
    e = earliest(c);
    k = 0;
    req_valid = 1'b1;
    req_cmd = c;
    do
    begin
      @(negedge clock);
      k++;
    end
    while (bus_valid !== 1'b1 && k < 400);
    req_valid = 1'b0;
    check(bus_cmd === c && cyc >= e && cyc <= e + slack, "command slot");
    t[c] = cyc;
    // Let an edge pass so the next request is raised at a later step
    @(negedge clock);
  endtask : send

  task automatic wait_ready;
    n = 0;
    while (req_ready !== 1'b1 && n < 60)
    begin
      @(negedge clock);
      n++;
    end
  endtask : wait_ready

  task automatic refresh_all;
    wait_ready();
    check(refresh_due === 1'b1, "burst pending");
    repeat (BANKS) send(mpm_pkg::MPM_CMD_REFR, 1);
    @(negedge clock);
    check(refresh_due === 1'b0, "burst done");
  endtask : refresh_all

  initial
  begin
    foreach (t[i]) t[i] = -999;
    void'($urandom(67));
    repeat (5) @(negedge clock);
    rst = 1'b0;
    t_go = cyc + PAUSE + 1;
    send(mpm_pkg::MPM_CMD_READ, 3);
    check(pause_done === 1'b1, "pause flag");
    $display("test pause done");
    send(mpm_pkg::MPM_CMD_CC, 1);
    send(mpm_pkg::MPM_CMD_READ, 1);
    send(mpm_pkg::MPM_CMD_ROWACT, 1);
    send(mpm_pkg::MPM_CMD_COL, 1);
    $display("test spacing done");
    repeat (30)
    begin
      req_self_refresh = 1'($urandom);
      repeat ($urandom_range(0, 3)) @(negedge clock);
      send(pick[$urandom_range(0, 4)], 1);
    end
    $display("test random done");
    send(mpm_pkg::MPM_CMD_TCE, 1);
    send(mpm_pkg::MPM_CMD_TEMP_CALIBRATE_COMMAND, 1);
    check(temp_calibrate_command_quiet === 1'b0, "quiet early");
    @(negedge clock);
    check(temp_calibrate_command_quiet === 1'b1, "quiet start");
    send(mpm_pkg::MPM_CMD_READ, 1);
    $display("test temperature done");
    req_self_refresh = 1'b0;
    send(mpm_pkg::MPM_CMD_NAP, 1);
    check(row_quiet_bit === 1'b1 && column_quiet_bit === 1'b1, "quiet bits");
    check(clk_stop_ok === 1'b0, "clock stop early");
    send(mpm_pkg::MPM_CMD_EXIT, 2);
    wait_ready();
    check(refresh_due === 1'b0, "no burst");
    $display("test nap exit done");
    req_self_refresh = 1'b1;
    send(mpm_pkg::MPM_CMD_NAP, 1);
    n = 0;
    do
    begin
      @(negedge clock);
      n++;
    end
    while (bus_valid !== 1'b1 && n < 300);
    check(bus_cmd === mpm_pkg::MPM_CMD_EXIT && n >= 100 && n <= 140, "nap limit");
    repeat (2) @(negedge clock);
    refresh_all();
    $display("test nap limit done");
    send(mpm_pkg::MPM_CMD_PDN, 1);
    send(mpm_pkg::MPM_CMD_EXIT, 2);
    refresh_all();
    $display("test power-down done");
    check(dev_errs == 0, "device saw spacing fault");
    finish_test();
  end
endmodule : memory_power_and_maintenance_timing_bench
